// *** design/sass_pkg.sv ***
// sass_pkg: register map, field layout, pin command codes and sequencer states
// assumes: included before the sequencer; AXI4-Lite offsets are byte addresses
`default_nettype none
package sass_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_WAIT = 8'h00; // area_wait_control
  localparam logic [7:0] OFS_ADDR = 8'h04; // access address
  localparam logic [7:0] OFS_WDATA = 8'h08; // write data word
  localparam logic [7:0] OFS_CMD = 8'h0C; // start / direction
  localparam logic [7:0] OFS_STAT = 8'h10; // busy / done
  localparam logic [7:0] OFS_RDATA = 8'h14; // captured read word
  // ==========================================================
  // area_wait_control field positions and reset value
  localparam int TRP_LSB = 13; // precharge_completion_field
  localparam int RCD_LSB = 10; // row_to_column_delay_field
  localparam int CL_LSB = 7; // read_latency_field
  localparam int TRWL_LSB = 3; // write-recovery field
  localparam logic [31:0] WAIT_RST = 32'h0000_4891;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int AP_BIT = 10; // auto-precharge address bit
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ==========================================================
  // {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_DESEL = 4'b1111;
  localparam logic [3:0] PIN_NOP = 4'b0111;
  localparam logic [3:0] PIN_ROW_OPEN = 4'b0011; // row_open_cmd
  localparam logic [3:0] PIN_COL_READ = 4'b0101;
  localparam logic [3:0] PIN_COL_WRITE = 4'b0100; // column_write_autoprecharge_cmd
  // ==========================================================
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_OPEN = 4'b0001, // row_open_cycle
    ST_RCD = 4'b0010,
    ST_COLUMN = 4'b0011, // column_command_cycle
    ST_LAT = 4'b0100,
    ST_CAPTURE = 4'b0101, // data_capture_cycle
    ST_TDE = 4'b0110,
    ST_REC = 4'b0111, // write_recovery_cycle
    ST_PRE = 4'b1000, // precharge_wait_cycle
    ST_DONE = 4'b1001
  } sass_state_t;
endpackage : sass_pkg
`default_nettype wire

// *** design/sass_sequencer.sv ***
// sass_sequencer: single SDRAM read/write sequencer behind an AXI4-Lite slave
// assumes: the SDRAM is clocked from aclk, so dq_in is synchronous and not resynchronised
// How it works
// - every access starts with a row open command on bank and row
// - row_to_column_delay_field wait cycles follow the row open
// - read: column read with auto-precharge in the column cycle
// - read: latency wait cycles until data is valid on the pins
// - read: the data word is captured in the data cycle
// - read: exactly one idle cycle always follows the capture
// - precharge_completion_field wait cycles end every access
// - write: column write with auto-precharge, data driven that cycle
// - write: write-recovery field cycles before the precharge wait
// - row-to-column field value is the wait count, 2'b10 gives two
// - read_latency_field 2'b01 means latency two, one wait cycle
//
// Register access over AXI4-Lite and the address map were left to the implementer.
`default_nettype none
module sass_sequencer #(
  parameter int ROW_W = 12,
  parameter int COL_W = 9,
  parameter int BANK_W = 2,
  parameter int DQ_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic dram_cs_n,
  output logic dram_ras_n,
  output logic dram_cas_n,
  output logic dram_we_n,
  output logic [ROW_W-1:0] dram_addr,
  output logic [BANK_W-1:0] dram_ba,
  output logic [DQ_W-1:0] dram_dq_out,
  output logic dram_dq_oe,
  input wire logic [DQ_W-1:0] dram_dq_in
);
  import sass_pkg::*;

  // ==========================================================
  // elaboration checks
  if (ROW_W < AP_BIT + 1 || COL_W > AP_BIT || DQ_W > 32 || ROW_W + COL_W + BANK_W > 32) begin : g_bad
    $error("sass_sequencer: unsupported geometry");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================
  // bus side state
  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d;
  logic [3:0] ws_q, ws_d;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] wait_q, wait_d, addr_q, addr_d, wdat_q, wdat_d;
  logic start, start_wr;
  // sequencer state
  sass_state_t st_q, st_d;
  logic [1:0] cnt_q, cnt_d;
  logic wr_q, wr_d, done_q, done_d;
  logic [DQ_W-1:0] rd_q, rd_d;
  logic [3:0] pin_q, pin_d;
  logic [ROW_W-1:0] pa_q, pa_d;
  logic [BANK_W-1:0] ba_q, ba_d;
  logic [DQ_W-1:0] dqo_q, dqo_d;
  logic oe_q, oe_d;

  wire logic [1:0] rcd = wait_q[RCD_LSB +: 2];
  wire logic [1:0] cl = wait_q[CL_LSB +: 2];
  wire logic [1:0] trwl = wait_q[TRWL_LSB +: 2];
  wire logic [1:0] trp = wait_q[TRP_LSB +: 2];
  wire logic [7:0] wa = {awa_d[7:2], 2'b00};
  wire logic [7:0] ra = {s_axi_araddr[7:2], 2'b00};

  // register writes and reads, write address and data taken in either order
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    wait_d = wait_q;
    addr_d = addr_q;
    wdat_d = wdat_q;
    start = 1'b0;
    start_wr = 1'b0;
    if (s_axi_awvalid && awready_q) begin
      awa_d = s_axi_awaddr;
      aw_full_d = 1'b1;
    end
    if (s_axi_wvalid && wready_q) begin
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
      w_full_d = 1'b1;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_d && w_full_d && !bvalid_q) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      unique case (wa)
        OFS_WAIT: wait_d = merge(wait_q, wd_d, ws_d);
        OFS_ADDR: addr_d = merge(addr_q, wd_d, ws_d);
        OFS_WDATA: wdat_d = merge(wdat_q, wd_d, ws_d);
        OFS_CMD: begin
          // a start while busy is dropped
          start = ws_d[0] && wd_d[CMD_START_BIT] && st_q == ST_IDLE;
          start_wr = wd_d[CMD_WRITE_BIT];
        end
        OFS_STAT, OFS_RDATA: ;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = !aw_full_d;
    wready_d = !w_full_d;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      arready_d = 1'b0;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      unique case (ra)
        OFS_WAIT: rdata_d = wait_q;
        OFS_ADDR: rdata_d = addr_q;
        OFS_WDATA: rdata_d = wdat_q;
        OFS_CMD: rdata_d = {31'h0000_0000, wr_q};
        OFS_STAT: rdata_d = {30'h0000_0000, done_q, st_q != ST_IDLE};
        OFS_RDATA: rdata_d[DQ_W-1:0] = rd_q;
        default: rresp_d = RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================
  // access sequencer; pin values follow the next state so they stand with it
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    done_d = done_q;
    rd_d = rd_q;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin
          wr_d = start_wr;
          done_d = 1'b0;
          st_d = ST_OPEN;
        end
      end
      ST_OPEN: begin
        st_d = (rcd != 2'd0) ? ST_RCD : ST_COLUMN;
        cnt_d = rcd - 2'd1;
      end
      ST_COLUMN: begin
        if (wr_q) begin
          st_d = (trwl != 2'd0) ? ST_REC : ((trp != 2'd0) ? ST_PRE : ST_DONE);
          cnt_d = (trwl != 2'd0) ? trwl - 2'd1 : trp - 2'd1;
        end else begin
          st_d = (cl != 2'd0) ? ST_LAT : ST_CAPTURE;
          cnt_d = cl - 2'd1;
        end
      end
      ST_CAPTURE: begin
        rd_d = dram_dq_in;
        st_d = ST_TDE;
      end
      ST_TDE, ST_REC: begin
        if (st_q == ST_REC && cnt_q != 2'd0) begin
          cnt_d = cnt_q - 2'd1;
        end else begin
          st_d = (trp != 2'd0) ? ST_PRE : ST_DONE;
          cnt_d = trp - 2'd1;
        end
      end
      ST_RCD, ST_LAT, ST_PRE: begin
        if (cnt_q != 2'd0) begin
          cnt_d = cnt_q - 2'd1;
        end else begin
          st_d = (st_q == ST_RCD) ? ST_COLUMN : ((st_q == ST_LAT) ? ST_CAPTURE : ST_DONE);
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    pin_d = (st_d == ST_IDLE || st_d == ST_DONE) ? PIN_DESEL : PIN_NOP;
    pa_d = '0;
    ba_d = addr_q[ROW_W+COL_W +: BANK_W];
    oe_d = 1'b0;
    dqo_d = wdat_q[DQ_W-1:0];
    if (st_d == ST_OPEN) begin
      pin_d = PIN_ROW_OPEN;
      pa_d = addr_q[COL_W +: ROW_W];
    end else if (st_d == ST_COLUMN) begin
      pin_d = wr_d ? PIN_COL_WRITE : PIN_COL_READ;
      pa_d[COL_W-1:0] = addr_q[COL_W-1:0];
      pa_d[AP_BIT] = 1'b1;
      oe_d = wr_d;
    end
  end

  // ==========================================================
  // registers; ce low freezes everything, but a synchronous reset still loads its values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      wait_q <= WAIT_RST;
      addr_q <= 32'h0000_0000;
      wdat_q <= 32'h0000_0000;
      st_q <= ST_IDLE;
      cnt_q <= 2'd0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      rd_q <= '0;
      pin_q <= PIN_DESEL;
      pa_q <= '0;
      ba_q <= '0;
      dqo_q <= '0;
      oe_q <= 1'b0;
    end else if (ce) begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      wait_q <= wait_d;
      addr_q <= addr_d;
      wdat_q <= wdat_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      done_q <= done_d;
      rd_q <= rd_d;
      pin_q <= pin_d;
      pa_q <= pa_d;
      ba_q <= ba_d;
      dqo_q <= dqo_d;
      oe_q <= oe_d;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n} = pin_q;
  assign dram_addr = pa_q;
  assign dram_ba = ba_q;
  assign dram_dq_out = dqo_q;
  assign dram_dq_oe = oe_q;

  // ==========================================================
  // checks; dwell counts cycles spent in the current state
  logic [2:0] dwell_q, dwell_d;
  // restart on a state change, saturate so a long stay cannot wrap
  always_comb begin
    dwell_d = dwell_q;
    if (st_d != st_q) begin
      dwell_d = 3'd0;
    end else if (dwell_q != 3'd7) begin
      dwell_d = dwell_q + 3'd1;
    end
  end
  // frozen with the sequencer while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dwell_q <= 3'd0;
    end else if (ce) begin
      dwell_q <= dwell_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  a_row_open_first: assert property (st_q == ST_IDLE && start |=> st_q == ST_OPEN && pin_q == PIN_ROW_OPEN)
    else $error("no row open at access start");
  a_rcd_length: assert property (st_q == ST_RCD && st_d != ST_RCD |-> 32'(dwell_q) + 1 == 32'(rcd))
    else $error("row to column wait count wrong");
  a_rcd_skip: assert property (st_q == ST_OPEN |=> (st_q == ST_RCD) == ($past(rcd) != 2'd0))
    else $error("row to column wait entered wrongly");
  a_read_cmd: assert property (st_q == ST_COLUMN && !wr_q |-> pin_q == PIN_COL_READ && pa_q[AP_BIT] && !oe_q)
    else $error("bad column read command");
  a_lat_length: assert property (st_q == ST_COLUMN && !wr_q |=> (st_q == ST_CAPTURE) == ($past(cl) == 2'd0))
    else $error("latency wait entered wrongly");
  a_lat_count: assert property (st_q == ST_LAT && st_d != ST_LAT |-> 32'(dwell_q) + 1 == 32'(cl))
    else $error("latency wait count wrong");
  a_capture_word: assert property (st_q == ST_CAPTURE |=> rd_q == $past(dram_dq_in))
    else $error("read word not captured");
  a_one_idle: assert property (st_q == ST_CAPTURE |=> st_q == ST_TDE ##1 st_q != ST_TDE)
    else $error("idle cycle after capture not single");
  a_pre_count: assert property (st_q == ST_PRE && st_d != ST_PRE |-> 32'(dwell_q) + 1 == 32'(trp))
    else $error("precharge wait count wrong");
  a_write_cmd: assert property (st_q == ST_COLUMN && wr_q |-> pin_q == PIN_COL_WRITE && oe_q && pa_q[AP_BIT]
                                && dram_dq_out == wdat_q[DQ_W-1:0])
    else $error("bad column write command");
  a_rec_count: assert property (st_q == ST_REC && st_d != ST_REC |-> 32'(dwell_q) + 1 == 32'(trwl))
    else $error("write recovery count wrong");
endmodule : sass_sequencer
`default_nettype wire

// *** test/sass_sdram_model.sv ***
// sass_sdram_model: behavioural SDR SDRAM, one word per column, burst length one
// assumes: clocked by aclk; lat carries the read latency wait count
`default_nettype none
module sass_sdram_model (
  input wire logic aclk,
  input wire logic [3:0] cmd,
  input wire logic [11:0] addr,
  input wire logic [1:0] ba,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic [1:0] lat,
  output logic [15:0] dq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import sass_pkg::*;
  // ==========================================================
  // storage, open row and read pipe
  logic [15:0] mem [int];
  logic [11:0] row_q = 12'h000;
  logic [1:0] ba_q = 2'h0;
  logic [3:0] pipe_q = 4'h0;
  logic [15:0] rd_q = 16'h0000;
  logic [15:0] noise_q = 16'h5a5a;
  int key;
  always @(posedge aclk) begin
    key = int'({ba_q, row_q, addr[8:0]});
    noise_q <= noise_q + 16'h1357; // released lines never hold a stale word
    pipe_q <= {pipe_q[2:0], cmd == PIN_COL_READ && addr[AP_BIT]};
    if (cmd == PIN_ROW_OPEN) begin
      row_q <= addr;
      ba_q <= ba;
    end
    if (cmd == PIN_COL_WRITE && addr[AP_BIT] && dq_oe) begin
      mem[key] = dq_out;
    end
    if (cmd == PIN_COL_READ) begin
      rd_q <= mem.exists(key) ? mem[key] : 16'h0000;
    end
  end
  // word valid only in the capture cycle
  assign dq_in = pipe_q[lat] ? rd_q : noise_q;
endmodule : sass_sdram_model
`default_nettype wire

// *** test/sass_sequencer_test.sv ***
// sass_sequencer_test: single read/write sequences against the SDRAM model
// assumes: sass_pkg and the model compiled first; one 20 MHz clock
`default_nettype none
module sass_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sass_pkg::*;
  // ==========================================================
  // signals and case table
  typedef struct {logic [1:0] rcd, cl, trp, trwl; logic wr; logic [22:0] a; logic [15:0] d;} sass_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n, dram_dq_oe, exp_wr;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, dram_ba, lat, exp_ba, rsp;
  logic [11:0] dram_addr, exp_row;
  logic [15:0] dram_dq_out, dram_dq_in, exp_d;
  logic [8:0] exp_col;
  logic [3:0] cmd;
  int fail_count = 0, num_checks = 0, cyc = 0, t_open = 0, gap = 0, act_len = 0, opens = 0, n0;
  sass_row_t rows [7] = '{
    '{2'h2, 2'h1, 2'h2, 2'h2, 1'h1, 23'h12_3456, 16'hbeef},
    '{2'h2, 2'h1, 2'h2, 2'h2, 1'h0, 23'h12_3456, 16'hbeef},
    '{2'h0, 2'h0, 2'h0, 2'h0, 1'h1, 23'h40_0a05, 16'h0001},
    '{2'h0, 2'h0, 2'h0, 2'h0, 1'h0, 23'h40_0a05, 16'h0001},
    '{2'h3, 2'h3, 2'h3, 2'h3, 1'h1, 23'h7f_ffff, 16'hffff},
    '{2'h3, 2'h3, 2'h3, 2'h3, 1'h0, 23'h7f_ffff, 16'hffff},
    '{2'h1, 2'h2, 2'h1, 2'h1, 1'h0, 23'h12_3456, 16'hbeef}};
  assign cmd = {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n};
  // ==========================================================
  // design and memory model
  sass_sequencer DUT (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dram_cs_n,
    .dram_ras_n, .dram_cas_n, .dram_we_n, .dram_addr, .dram_ba, .dram_dq_out, .dram_dq_oe, .dram_dq_in);
  sass_sdram_model u_mem (.aclk, .cmd, .addr(dram_addr), .ba(dram_ba), .dq_out(dram_dq_out),
    .dq_oe(dram_dq_oe), .lat, .dq_in(dram_dq_in));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ==========================================================
  // compare, closing report, bus tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  task automatic hang();
    fail_count++;
    end_of_test();
  endtask : hang
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 99) hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 99) hang();
  endtask : axi_rd
  task automatic wait_done();
    int n;
    for (n = 0; n < 40; n++) begin
      axi_rd(OFS_STAT, v, rsp);
      if (v[STAT_DONE_BIT] === 1'b1) break;
    end
    if (n == 40) hang();
  endtask : wait_done
  // one access with the waits and direction of a table row
  task automatic run(input sass_row_t r);
    logic [31:0] w;
    w = (32'(r.trp) << TRP_LSB) | (32'(r.rcd) << RCD_LSB) | (32'(r.cl) << CL_LSB) | (32'(r.trwl) << TRWL_LSB);
    exp_row = r.a[20:9];
    exp_col = r.a[8:0];
    exp_ba = r.a[22:21];
    exp_wr = r.wr;
    exp_d = r.d;
    lat = r.cl;
    axi_wr(OFS_WAIT, w, rsp);
    axi_wr(OFS_ADDR, 32'(r.a), rsp);
    axi_wr(OFS_WDATA, 32'(r.d), rsp);
    n0 = opens;
    axi_wr(OFS_CMD, {30'h0, r.wr, 1'b1}, rsp);
    wait_done();
    chk("opens", opens - n0, 1);
    chk("gap", gap, r.rcd + 1);
    chk("len", act_len, r.wr ? 2 + r.rcd + r.trwl + r.trp : 4 + r.rcd + r.cl + r.trp);
    // direction of the last accepted start reads back
    axi_rd(OFS_CMD, v, rsp);
    chk("dir", v, 32'(r.wr));
    if (!r.wr) begin
      axi_rd(OFS_RDATA, v, rsp);
      chk("rdata", v, 32'(r.d));
    end
  endtask : run
  // ==========================================================
  // pin monitor: command placement and address fields
  always @(posedge aclk) begin
    cyc++;
    if (cmd == PIN_ROW_OPEN) begin
      t_open = cyc;
      act_len = 0;
      opens++;
      chk("row", 32'(dram_addr), 32'(exp_row));
      chk("bank", 32'(dram_ba), 32'(exp_ba));
    end
    if (dram_cs_n === 1'b0) act_len++;
    if (cmd == PIN_COL_READ || cmd == PIN_COL_WRITE) begin
      gap = cyc - t_open;
      chk("col_cmd", 32'(cmd), exp_wr ? 32'(PIN_COL_WRITE) : 32'(PIN_COL_READ));
      chk("col_addr", 32'(dram_addr), 32'(exp_col) | 32'h0000_0400);
      chk("dq_oe", 32'(dram_dq_oe), 32'(exp_wr));
      if (exp_wr) chk("dq_out", 32'(dram_dq_out), 32'(exp_d));
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    {exp_row, exp_col, exp_ba, exp_wr, exp_d, lat} = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_WAIT, v, rsp);
    chk("wait_rst", v, WAIT_RST);
    foreach (rows[i]) run(rows[i]);
    // unmapped offset answers with an error
    axi_rd(8'h40, v, rsp);
    chk("ur_resp", 32'(rsp), 32'(RESP_SLVERR));
    chk("ur_data", v, 32'h0000_0000);
    axi_wr(8'h40, 32'h1234_5678, rsp);
    chk("uw_resp", 32'(rsp), 32'(RESP_SLVERR));
    // second start during an access is dropped
    n0 = opens;
    axi_wr(OFS_CMD, 32'h0000_0001, rsp);
    axi_wr(OFS_CMD, 32'h0000_0001, rsp);
    chk("busy_resp", 32'(rsp), 32'(RESP_OKAY));
    // still in the first access: busy set, done cleared by the start
    axi_rd(OFS_STAT, v, rsp);
    chk("busy", v, 32'h0000_0001);
    wait_done();
    chk("dropped", opens - n0, 1);
    // reset in mid-access
    axi_wr(OFS_WAIT, 32'h0000_0000, rsp);
    axi_wr(OFS_CMD, 32'h0000_0001, rsp);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk("rst_pins", 32'(cmd), 32'(PIN_DESEL));
    chk("rst_oe", 32'(dram_dq_oe), 32'h0000_0000);
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(OFS_WAIT, v, rsp);
    chk("wait_rst2", v, WAIT_RST);
    end_of_test();
  end
endmodule : sass_sequencer_test
`default_nettype wire
